/* rtl/vpg_fifo_mem.sv */
// word memory of the display fifo, registered read with write bypass
`timescale 1ns/1ps
module vpg_fifo_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 1280,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic [WIDTH-1:0]      rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // storage array
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port, new data wins on a same-address write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (wr_en && wr_addr == rd_addr) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : vpg_fifo_mem

/* rtl/vpg_pkg.sv */
// constants and types shared by the video port global control block
// Notes on behaviour
// - raw display fifo holds 5120 bytes, one stream
// - capacity 5120/3840/2560/1280 samples by packing
// - display output sustains 110 MHz pixel rate; code takes at most one sample per two sys_clk cycles, 10 MHz at 50 ns
// - control bits 31-16 and 13-8 read zero
// - writing one starts soft reset, self-clears
// - soft reset flushes fifo, resets all registers; code leaves irq status bit 2 (soft reset done) set afterwards
// - soft reset makes clock pins inputs, pins float
// - hardware or soft reset sets halt flag
// - other control fields writable only while halted
// - writing one to halt flag releases port
// - bit 7 inverts display clock, display only
// - falsely acknowledge dma while port not active
// - bit 1 selects capture or display direction
// - bit 0 dual channel, forced zero if disabled
// - bit 2 enables transport stream capture
package vpg_pkg;

    // register byte addresses
    localparam logic [11:0] ADDR_PORT_CONTROL   = 12'h000;
    localparam logic [11:0] ADDR_PORT_CONDITION = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STATUS     = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK       = 12'h00C;
    localparam logic [11:0] ADDR_DISPLAY_CONFIG = 12'h010;

    // port control field positions
    localparam int BIT_SOFT_RESET = 15;
    localparam int BIT_HALT       = 14;
    localparam int BIT_CLK_POL    = 7;
    localparam int BIT_CTL_POL_LO = 4;
    localparam int BIT_TRANSPORT  = 2;
    localparam int BIT_DISPLAY    = 1;
    localparam int BIT_DUAL       = 0;
    localparam logic [7:0] CTL_FIELD_MASK = 8'hF7;
    localparam logic [7:0] CTL_RESET      = 8'h00;

    // display config and interrupt field positions
    localparam int BIT_DISPLAY_SELECT_EN   = 0;
    localparam int IRQ_UNDERFLOW = 0;
    localparam int IRQ_OVERFLOW  = 1;
    localparam int IRQ_SRST_DONE = 2;
    localparam int IRQ_BITS      = 3;

    // display fifo sizing
    localparam int FIFO_BYTES       = 5120;
    localparam int FIFO_WORDS       = FIFO_BYTES / 4;
    localparam int SAMPLES_8BIT     = 5120;
    localparam int SAMPLES_10DENSE  = 3840;
    localparam int SAMPLES_16BIT    = 2560;
    localparam int SAMPLES_20BIT    = 1280;
    localparam int PIXEL_RATE_MHZ   = 110;

    // soft reset duration
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int SRST_TIME_NS      = 800;
    localparam int SRST_CYCLES       =
        (SRST_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int SRST_CW           = $clog2(SRST_CYCLES + 1);

    typedef enum logic [1:0] {
        PACK_8   = 2'h0,
        PACK_10D = 2'h1,
        PACK_16  = 2'h2,
        PACK_20  = 2'h3
    } vpg_pack_t;

    typedef enum logic [2:0] {
        ST_HALTED = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_SRESET = 3'b100
    } vpg_state_t;

endpackage : vpg_pkg

/* rtl/vpg_port_ctrl.sv */
// video port global control: apb registers, display fifo, pixel pins
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module vpg_port_ctrl
    import vpg_pkg::*;
#(
    parameter int FIFO_DEPTH   = FIFO_WORDS,
    parameter bit DUAL_DISABLE = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        port_enable,
    input  wire logic        dma_req,
    input  wire logic        dma_write,
    input  wire logic [31:0] dma_wdata,
    output logic             dma_ack,
    output logic [31:0]      dma_rdata,
    input  wire logic        pixel_clock_a,
    input  wire logic        pixel_clock_b_in,
    output logic             display_clock_out,
    output logic             pixel_clock_b_oe,
    input  wire logic [19:0] video_data_pins_in,
    output logic [19:0]      video_data_pins_out,
    output logic             video_data_pins_oe,
    input  wire logic [2:0]  video_control_pins_in,
    output logic [2:0]       video_control_pins_out,
    output logic             video_control_pins_oe,
    output logic             irq
);
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam int CW = AW + 1;
    localparam logic [AW-1:0] PTR_LAST = AW'(FIFO_DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(FIFO_DEPTH);

    vpg_state_t           st_q;
    logic [SRST_CW-1:0]   srst_cnt_q;
    logic [7:0]           ctl_q;
    logic                 display_select_en_q;
    vpg_pack_t            pack_q;
    logic [IRQ_BITS-1:0]  irq_stat_q;
    logic [IRQ_BITS-1:0]  irq_mask_q;
    logic [AW-1:0]        wr_ptr_q;
    logic [AW-1:0]        rd_ptr_q;
    logic [AW-1:0]        rd_ptr_d;
    logic [CW-1:0]        cnt_q;
    logic [1:0]           sub_q;
    logic                 clk_a_s;
    logic                 clk_a_prev_q;
    logic [31:0]          rd_word;
    logic                 hit;
    logic [31:0]          head_word;
    logic [19:0]          sample;
    logic [1:0]           sub_last;
    logic                 sres;
    logic                 halted;
    logic                 acc;
    logic                 wr;
    logic                 ctl_wr;
    logic                 display_select_on;
    logic                 dma_take;
    logic                 push;
    logic                 pop;
    logic                 pix_step;
    logic                 fifo_empty;
    logic                 fifo_full;
    logic                 pin_drive;
    logic                 clk_flip;
    logic [IRQ_BITS-1:0]  ev;

    // pixel clock crosses into the system clock domain
    vpg_sync u_sync_clk_a (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pin_in    (pixel_clock_a),
        .level_out (clk_a_s)
    );

    // 5120-byte display fifo, one word per dma transfer
    vpg_fifo_mem #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH),
        .AW    (AW)
    ) u_fifo_mem (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (push),
        .wr_addr (wr_ptr_q),
        .wr_data (dma_wdata),
        .rd_addr (rd_ptr_d),
        .rd_data (head_word)
    );

    // shorthand status and apb strobes
    assign sres       = (st_q == ST_SRESET);
    assign halted     = (st_q != ST_ACTIVE);
    assign acc        = psel & penable & pready;
    assign wr         = acc & pwrite;
    assign ctl_wr     = wr & (paddr == ADDR_PORT_CONTROL);
    assign fifo_empty = (cnt_q == '0);
    assign fifo_full  = (cnt_q == CNT_FULL);

    // display runs only when enabled, released and not transport capture
    assign display_select_on = (st_q == ST_ACTIVE) & port_enable & display_select_en_q
                   & ctl_q[BIT_DISPLAY] & ~ctl_q[BIT_TRANSPORT];

    // dma side: one ack per request, writes land only while displaying
    assign dma_take = dma_req & ~dma_ack;
    assign push     = dma_take & dma_write & display_select_on & ~fifo_full;

    // pixel side: one sample per rising pixel clock edge
    assign pix_step = clk_a_s & ~clk_a_prev_q & display_select_on;
    assign pop      = pix_step & ~fifo_empty & (sub_q == sub_last);
    assign rd_ptr_d = pop ? ((rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1)
                          : rd_ptr_q;

    // events that raise sticky status bits
    assign ev[IRQ_UNDERFLOW] = pix_step & fifo_empty;
    assign ev[IRQ_OVERFLOW]  = dma_take & dma_write & display_select_on & fifo_full;
    assign ev[IRQ_SRST_DONE] = sres & (srst_cnt_q == '0);

    // register read mux and address decode
    always_comb begin
        rd_word = 32'h0;
        hit     = 1'b1;
        if (paddr == ADDR_PORT_CONTROL) begin
            rd_word = {16'h0, sres, halted, 6'h0, ctl_q};
        end else if (paddr == ADDR_PORT_CONDITION) begin
            rd_word = {16'(cnt_q), 13'h0, fifo_full, fifo_empty,
                       DUAL_DISABLE};
        end else if (paddr == ADDR_IRQ_STATUS) begin
            rd_word = {29'h0, irq_stat_q};
        end else if (paddr == ADDR_IRQ_MASK) begin
            rd_word = {29'h0, irq_mask_q};
        end else if (paddr == ADDR_DISPLAY_CONFIG) begin
            rd_word = {29'h0, pack_q, display_select_en_q};
        end else begin
            hit = 1'b0;
        end
    end

    // sample extraction by packing mode
    always_comb begin
        sub_last = 2'h0;
        sample   = 20'h0;
        case (pack_q)
            PACK_8: begin
                sub_last = 2'h3;
                sample   = {12'h0, head_word[8*sub_q +: 8]};
            end
            PACK_10D: begin
                sub_last = 2'h2;
                sample   = {10'h0, head_word[10*sub_q +: 10]};
            end
            PACK_16: begin
                sub_last = 2'h1;
                sample   = {4'h0, head_word[16*sub_q +: 16]};
            end
            default: begin
                sub_last = 2'h0;
                sample   = head_word[19:0];
            end
        endcase
    end

    // apb slave: no wait states, read data captured in setup
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0 : rd_word;
            end
        end
    end

    // halt / active / soft reset sequencing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= ST_HALTED;
            srst_cnt_q <= '0;
        end else begin
            case (st_q)
                ST_HALTED: begin
                    if (ctl_wr && pwdata[BIT_SOFT_RESET]) begin
                        st_q       <= ST_SRESET;
                        srst_cnt_q <= SRST_CW'(SRST_CYCLES - 1);
                    end else if (ctl_wr && pwdata[BIT_HALT]) begin
                        st_q <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (ctl_wr && pwdata[BIT_SOFT_RESET]) begin
                        st_q       <= ST_SRESET;
                        srst_cnt_q <= SRST_CW'(SRST_CYCLES - 1);
                    end
                end
                ST_SRESET: begin
                    if (srst_cnt_q == '0) begin
                        st_q <= ST_HALTED;
                    end else begin
                        srst_cnt_q <= srst_cnt_q - 1'b1;
                    end
                end
                default: begin
                    st_q <= ST_HALTED;
                end
            endcase
        end
    end

    // control fields, changeable only while halted before this write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= CTL_RESET;
        end else if (sres) begin
            ctl_q <= CTL_RESET;
        end else if (ctl_wr && !pwdata[BIT_SOFT_RESET]
                     && st_q == ST_HALTED) begin
            ctl_q <= pwdata[7:0] & CTL_FIELD_MASK;
            if (DUAL_DISABLE) begin
                ctl_q[BIT_DUAL] <= 1'b0;
            end
        end
    end

    // display config and interrupt mask
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            display_select_en_q  <= 1'b0;
            pack_q     <= PACK_8;
            irq_mask_q <= '0;
        end else if (sres) begin
            display_select_en_q  <= 1'b0;
            pack_q     <= PACK_8;
            irq_mask_q <= '0;
        end else if (wr && paddr == ADDR_DISPLAY_CONFIG) begin
            display_select_en_q <= pwdata[BIT_DISPLAY_SELECT_EN];
            pack_q    <= vpg_pack_t'(pwdata[2:1]);
        end else if (wr && paddr == ADDR_IRQ_MASK) begin
            irq_mask_q <= pwdata[IRQ_BITS-1:0];
        end
    end

    // sticky status, a read clears only the bits it returned
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else if (sres) begin
            irq_stat_q <= ev;
        end else if (acc && !pwrite && paddr == ADDR_IRQ_STATUS) begin
            irq_stat_q <= (irq_stat_q & ~prdata[IRQ_BITS-1:0]) | ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // fifo pointers and fill count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else if (sres) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else begin
            rd_ptr_q <= rd_ptr_d;
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // dma acknowledge, every request answered so the bus never stalls
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_ack   <= 1'b0;
            dma_rdata <= 32'h0;
        end else begin
            dma_ack <= dma_take;
            if (dma_take) begin
                dma_rdata <= head_word;
            end
        end
    end

    // sample position within the head word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_q        <= 2'h0;
            clk_a_prev_q <= 1'b0;
        end else begin
            clk_a_prev_q <= clk_a_s;
            if (sres || !display_select_on) begin
                sub_q <= 2'h0;
            end else if (pix_step && !fifo_empty) begin
                sub_q <= (sub_q == sub_last) ? 2'h0 : sub_q + 1'b1;
            end
        end
    end

    // pin drivers, data, control and pixel clock b pins float during soft reset or capture
    assign pin_drive = ~sres & ctl_q[BIT_DISPLAY] & ~ctl_q[BIT_TRANSPORT];
    assign clk_flip  = ctl_q[BIT_CLK_POL] & ctl_q[BIT_DISPLAY];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            video_data_pins_out    <= 20'h0;
            video_data_pins_oe     <= 1'b0;
            display_clock_out      <= 1'b0;
            pixel_clock_b_oe       <= 1'b0;
            video_control_pins_out <= 3'h0;
            video_control_pins_oe  <= 1'b0;
        end else begin
            video_data_pins_oe     <= pin_drive;
            pixel_clock_b_oe       <= pin_drive;
            video_control_pins_oe  <= pin_drive;
            display_clock_out      <= clk_a_s ^ clk_flip;
            video_control_pins_out <= ctl_q[BIT_CTL_POL_LO +: 3];
            if (pix_step && !fifo_empty) begin
                video_data_pins_out <= sample;
            end
        end
    end

    // checks on the control and data paths
    localparam int SR_LAST = SRST_CYCLES - 1;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_rsvd_zero;
        psel && !penable && !pwrite && paddr == ADDR_PORT_CONTROL
        |=> prdata[31:16] == 16'h0 && prdata[13:8] == 6'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved control bits read nonzero");

    property p_srst_len;
        $rose(sres) |-> ##SR_LAST sres ##1 (st_q == ST_HALTED);
    endproperty
    a_srst_len: assert property (p_srst_len)
        else $error("soft reset length wrong");

    property p_flush;
        sres |=> cnt_q == '0 && ctl_q == CTL_RESET && irq_mask_q == '0;
    endproperty
    a_flush: assert property (p_flush)
        else $error("soft reset left state behind");

    property p_pins_float;
        sres |=> !video_data_pins_oe && !pixel_clock_b_oe
                 && !video_control_pins_oe;
    endproperty
    a_pins_float: assert property (p_pins_float)
        else $error("pins driven during soft reset");

    property p_halt_after;
        $fell(sres) |-> st_q == ST_HALTED
                        && (rd_word[BIT_HALT] || paddr != ADDR_PORT_CONTROL);
    endproperty
    a_halt_after: assert property (p_halt_after)
        else $error("halt not set after soft reset");

    property p_gate;
        ctl_wr && !halted |=> $stable(ctl_q);
    endproperty
    a_gate: assert property (p_gate)
        else $error("control changed while running");

    property p_release;
        ctl_wr && st_q == ST_HALTED && pwdata[BIT_HALT]
        && !pwdata[BIT_SOFT_RESET] |=> st_q == ST_ACTIVE ##0 !halted;
    endproperty
    a_release: assert property (p_release)
        else $error("halt release failed");

    property p_clk_pol;
        ##1 display_clock_out == ($past(clk_a_s)
            ^ ($past(ctl_q[BIT_CLK_POL]) & $past(ctl_q[BIT_DISPLAY])));
    endproperty
    a_clk_pol: assert property (p_clk_pol)
        else $error("display clock polarity wrong");

    property p_false_ack;
        dma_take && !display_select_on |=> dma_ack && $stable(wr_ptr_q);
    endproperty
    a_false_ack: assert property (p_false_ack)
        else $error("dma access not falsely acknowledged");

    property p_dual;
        !(DUAL_DISABLE && ctl_q[BIT_DUAL]);
    endproperty
    a_dual: assert property (p_dual)
        else $error("dual channel set while disabled");

    c_srst: cover property ($rose(sres) ##[1:40] $fell(sres));
    c_push: cover property (push ##[1:200] pop);
    c_under: cover property (ev[IRQ_UNDERFLOW] ##[1:20] irq);
    c_release: cover property (st_q == ST_HALTED ##1 st_q == ST_ACTIVE);

endmodule : vpg_port_ctrl

/* rtl/vpg_sync.sv */
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module vpg_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_q;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q    <= 1'b0;
            level_out <= 1'b0;
        end else begin
            meta_q    <= pin_in;
            level_out <= meta_q;
        end
    end
endmodule : vpg_sync

/* tb/test_video_port_global_control.sv */
// self-checking bench of the video port global control block
`timescale 1ns/1ps
module test_video_port_global_control;
    import vpg_pkg::*;
    localparam int DEPTH = 8;
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic        err;
    } vpg_row_t;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, dma_wdata, dma_rdata, rd;
    logic        port_enable, dma_req, dma_write, dma_ack, er;
    logic        pixel_clock_a, display_clock_out, pixel_clock_b_oe;
    logic [19:0] video_data_pins_out;
    logic        video_data_pins_oe, video_control_pins_oe, irq;
    logic [2:0]  video_control_pins_out;
    int          n_mismatch, n_checks, cycles;
    vpg_row_t    rows [11] = '{
        '{1'b0, ADDR_PORT_CONTROL, 32'h0, 32'h0000_4000, 1'b0},
        '{1'b1, ADDR_PORT_CONTROL, 32'hFFFF_3FFF, 32'h0, 1'b0},
        '{1'b0, ADDR_PORT_CONTROL, 32'h0, 32'h0000_40F7, 1'b0},
        '{1'b1, ADDR_PORT_CONTROL, 32'h0000_4002, 32'h0, 1'b0},
        '{1'b1, ADDR_PORT_CONTROL, 32'h0000_0080, 32'h0, 1'b0},
        '{1'b0, ADDR_PORT_CONTROL, 32'h0, 32'h0000_0002, 1'b0},
        '{1'b0, 12'h020, 32'h0, 32'h0, 1'b1},
        '{1'b1, ADDR_IRQ_MASK, 32'h7, 32'h0, 1'b0},
        '{1'b0, ADDR_IRQ_MASK, 32'h0, 32'h7, 1'b0},
        '{1'b1, ADDR_DISPLAY_CONFIG, 32'h1, 32'h0, 1'b0},
        '{1'b0, ADDR_DISPLAY_CONFIG, 32'h0, 32'h1, 1'b0}};

    vpg_port_ctrl #(.FIFO_DEPTH(DEPTH), .DUAL_DISABLE(1'b0)) u_vpg_port_ctrl (
        .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_enable(port_enable), .dma_req(dma_req),
        .dma_write(dma_write), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
        .dma_rdata(dma_rdata), .pixel_clock_a(pixel_clock_a),
        .pixel_clock_b_in(1'b0), .display_clock_out(display_clock_out),
        .pixel_clock_b_oe(pixel_clock_b_oe), .video_data_pins_in(20'h0),
        .video_data_pins_out(video_data_pins_out),
        .video_data_pins_oe(video_data_pins_oe),
        .video_control_pins_in(3'h0),
        .video_control_pins_out(video_control_pins_out),
        .video_control_pins_oe(video_control_pins_oe), .irq(irq));

    vpg_dma_model u_vpg_dma_model (.sys_clk(sys_clk), .dma_ack(dma_ack),
        .dma_req(dma_req), .dma_write(dma_write), .dma_wdata(dma_wdata));

    // compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, then an idle cycle
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // read a register and compare
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // pixel clock burst of 400 ns periods, sample e seen a period later
    task automatic pixel_burst(input int n);
        for (int e = 0; e < n; e++) begin
            if (e > 0) chk({12'h0, video_data_pins_out}, 32'(e));
            pixel_clock_a <= 1'b1;
            repeat (4) @(posedge sys_clk);
            pixel_clock_a <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        chk({12'h0, video_data_pins_out}, 32'(n));
    endtask : pixel_burst

    // verdict and end of run
    task automatic print_verdict;
        if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, port_enable, pixel_clock_a} = 6'h00;
        {paddr, pwdata, n_mismatch, n_checks, cycles} = '0;
        repeat (2) @(posedge sys_clk);
        rst_n       <= 1'b1;
        port_enable <= 1'b1;
        repeat (64) @(posedge sys_clk);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            chk({31'h0, er}, {31'h0, rows[i].err});
            if (!rows[i].wr) chk(rd, rows[i].exp);
        end
        u_vpg_dma_model.send(DEPTH + 1, 0);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        rdchk(ADDR_PORT_CONDITION, {16'(DEPTH), 16'h0004});
        rdchk(ADDR_IRQ_STATUS, 32'h2);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        pixel_burst(5);
        chk({31'h0, video_data_pins_oe & pixel_clock_b_oe}, 32'h1);
        apb(1'b1, ADDR_PORT_CONTROL, 32'h0000_8000);
        rdchk(ADDR_PORT_CONTROL, 32'h0000_C000);
        chk({29'h0, video_control_pins_oe, video_data_pins_oe,
             pixel_clock_b_oe}, 32'h0);
        for (int t = 0; t < 40 && rd === 32'h0000_C000; t++)
            apb(1'b0, ADDR_PORT_CONTROL, 32'h0);
        chk(rd, 32'h0000_4000);
        rdchk(ADDR_PORT_CONDITION, 32'h0000_0002);
        rdchk(ADDR_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        u_vpg_dma_model.send(1, 2);
        rdchk(ADDR_PORT_CONDITION, 32'h0000_0002);
        rdchk(ADDR_IRQ_STATUS, 32'h4);
        rdchk(ADDR_IRQ_STATUS, 32'h0);
        apb(1'b1, ADDR_PORT_CONTROL, 32'h0000_0080);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, display_clock_out}, 32'h0);
        apb(1'b1, ADDR_PORT_CONTROL, 32'h0000_40D2);
        repeat (4) @(posedge sys_clk);
        chk({31'h0, display_clock_out}, 32'h1);
        chk({28'h0, video_control_pins_out, video_control_pins_oe}, 32'hB);
        print_verdict();
    end
endmodule : test_video_port_global_control

/* tb/vpg_dma_model.sv */
// dma controller model that refills the display fifo
`timescale 1ns/1ps
module vpg_dma_model (
    input  wire logic   sys_clk,
    input  wire logic   dma_ack,
    output logic        dma_req,
    output logic        dma_write,
    output logic [31:0] dma_wdata
);
    // idle at start: no request pending
    initial begin
        dma_req   = 1'b0;
        dma_write = 1'b0;
        dma_wdata = 32'h0000_0000;
    end

    // n words, gap idle cycles apart, each held until acked
    task automatic send(input int n, input int gap);
        for (int k = 0; k < n; k++) begin
            dma_req   <= 1'b1;
            dma_write <= 1'b1;
            dma_wdata <= 32'h0403_0201 + k * 32'h0404_0404;
            do @(posedge sys_clk); while (dma_ack !== 1'b1);
            if (gap > 0 || k == n - 1) begin
                dma_req   <= 1'b0;
                dma_wdata <= ~dma_wdata; // released bus holds no stale word
                repeat (gap) @(posedge sys_clk);
            end
        end
    endtask : send
endmodule : vpg_dma_model
